// >>> hdl/iosad_pkg.sv
package iosad_pkg;

    // Address field layout
    localparam int IO_HI_MSB    = 31;
    localparam int IO_HI_LSB    = 29;
    localparam int IO_FLAG_BIT  = 29;
    localparam int REGION_MSB   = 28;
    localparam int REGION_LSB   = 23;
    localparam int NODE_MSB     = 22;
    localparam int NODE_LSB     = 19;
    localparam int WIN_NODE_MSB = 28;
    localparam int WIN_NODE_LSB = 25;
    localparam int SEC_NODE_MSB = 16;
    localparam int SEC_NODE_LSB = 13;
    localparam int WIN_OFF_MSB  = 24;
    localparam int REG_OFF_MSB  = 18;

    // I/O space bases for each addressing mode
    localparam logic [31:0] IO_BASE_32  = 32'hE000_0000;
    localparam logic [31:0] IO_BASE_30  = 32'h2000_0000;
    localparam logic [31:0] NODE_BASE_32 = 32'hE180_0000;
    localparam logic [31:0] NODE_BASE_30 = 32'h2180_0000;
    localparam logic [31:0] NODE_STRIDE = 32'h0008_0000;
    localparam logic [2:0]  IO_HI_ONES  = 3'h7;
    localparam logic [1:0]  MODE30_HI   = 2'h1;

    // Region codes in bits 28:23 (64 granules of 8 Mbyte)
    localparam logic [5:0] PRIV_LAST    = 6'h02;
    localparam logic [5:0] NODESPACE_RG = 6'h03;

    // Node numbers
    localparam logic [3:0] NODE_NONE_LO = 4'h0;
    localparam logic [3:0] NODE_NONE_HI = 4'hF;
    localparam logic [3:0] WIN_LO_FIRST = 4'h1;
    localparam logic [3:0] WIN_LO_LAST  = 4'h5;
    localparam logic [3:0] WIN_HI_FIRST = 4'hA;
    localparam logic [3:0] WIN_HI_LAST  = 4'hE;

    // Register offsets within a node's region
    localparam logic [18:0] OFF_DEVICE_TYPE = 19'h0_0000;
    localparam logic [18:0] OFF_BUS_ERROR   = 19'h0_0004;
    localparam logic [18:0] OFF_BUS_ERR_EXT = 19'h0_0034;

    // Reset values
    localparam logic [31:0] DEVICE_TYPE_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO32          = 32'h0000_0000;

    // Longword length code
    localparam logic [1:0] LEN_LONGWORD = 2'h0;

    typedef enum logic [2:0] {
        IOSAD_TGT_NONE   = 3'h0,
        IOSAD_TGT_MEMORY = 3'h1,
        IOSAD_TGT_PRIV   = 3'h2,
        IOSAD_TGT_NODE   = 3'h3,
        IOSAD_TGT_WINDOW = 3'h4
    } iosad_target_t;

    typedef enum logic [1:0] {
        IOSAD_ST_IDLE  = 2'h0,
        IOSAD_ST_RESP  = 2'h1,
        IOSAD_ST_FWD   = 2'h2
    } iosad_state_t;

    // One system bus reference
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  len;
        logic [31:0] addr;
        logic [31:0] wdata;
    } iosad_req_t;

    // Re-issued secondary bus reference
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  sec_node;
        logic [31:0] addr;
        logic [31:0] wdata;
    } iosad_fwd_t;

    // Decode result
    typedef struct packed {
        iosad_target_t tgt;
        logic [3:0]    node;
        logic          own;
    } iosad_dec_t;

endpackage

// >>> hdl/iosad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - References to the private region are kept local and never put on the shared bus.
// - The private region is E000 0000 to E17F FFFF, or 2000 0000 to 217F FFFF in 30-bit mode.
// - Nodespace is sixteen 512-Kbyte regions from E180 0000 to E1FF FFFF (or 2180 0000 to 21FF FFFF).
// - A node's region starts at the nodespace base plus node id times 80000.
// - Node ids 0 and F have no responder in nodespace.
// - Ten 32-Mbyte adapter windows: nodes 1-5 from E200 0000 and nodes A-E from F400 0000.
// - Node positions 6 to 9 get no adapter window.
// - In 30-bit mode addresses use leading 2 for E and 3 for F.
// - Each node has device_type at +00, bus_error at +04 and bus_error_extension at +34.
// - Longword references that hit this adapter's window are re-issued on the secondary bus.
// - The secondary address is the I/O base plus the offset into the window.
// - Only the secondary bus I/O space is reachable; no path to its memory space.
// - Bits 28:25 of a window address name the adapter's system bus node.
// - Bits 16:13 of a window address name the node on the secondary bus.
// - In 32-bit mode the I/O flag is set only when bits 31:29 are all ones; then only 28:0 count.
module iosad_decoder (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                mode30,
    input  wire logic [3:0]          node_id,
    input  wire logic                is_bridge,
    input  wire logic [31:0]         device_type_val,
    input  wire logic                err_event,
    input  wire logic [31:0]         err_info,
    input  wire iosad_pkg::iosad_req_t req,
    output var  iosad_pkg::iosad_dec_t dec_r,
    output logic                     local_hit_r,
    output logic                     bus_claim_r,
    output logic                     resp_valid_r,
    output logic [31:0]              resp_data_r,
    output var  iosad_pkg::iosad_fwd_t fwd_r
);
    import iosad_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for strap and error inputs
    logic       mode_s1_r, mode_s2_r;
    logic [3:0] node_s1_r, node_s2_r;
    logic       brg_s1_r,  brg_s2_r;
    logic       err_s1_r,  err_s2_r;

    // Two-flop synchronisers; first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            node_s1_r <= NODE_NONE_LO;
            node_s2_r <= NODE_NONE_LO;
            brg_s1_r  <= 1'b0;
            brg_s2_r  <= 1'b0;
            err_s1_r  <= 1'b0;
            err_s2_r  <= 1'b0;
        end else begin
            mode_s1_r <= mode30;
            mode_s2_r <= mode_s1_r;
            node_s1_r <= node_id;
            node_s2_r <= node_s1_r;
            brg_s1_r  <= is_bridge;
            brg_s2_r  <= brg_s1_r;
            err_s1_r  <= err_event;
            err_s2_r  <= err_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode functions

    // Window-owning node check
    function automatic logic has_window(input logic [3:0] n);
        has_window = (n >= WIN_LO_FIRST && n <= WIN_LO_LAST) ||
                     (n >= WIN_HI_FIRST && n <= WIN_HI_LAST);
    endfunction

    // I/O space test per mode
    function automatic logic is_io(input logic [31:0] a, input logic m30);
        if (m30)
            is_io = (a[IO_HI_MSB:IO_HI_LSB+1] == 2'h0) && a[IO_FLAG_BIT];
        else
            is_io = (a[IO_HI_MSB:IO_HI_LSB] == IO_HI_ONES);
    endfunction

    // Decode wires for the incoming reference
    logic [31:0]   a;
    logic          io_w;
    logic [5:0]    region_w;
    logic [3:0]    ns_node_w;
    logic [3:0]    win_node_w;
    logic          priv_w;
    logic          nodesp_w;
    logic          window_w;
    logic          ns_impl_w;
    logic          win_impl_w;
    iosad_dec_t    dec_w;
    logic [31:0]   node_base_w;
    logic [31:0]   own_base_w;
    logic [18:0]   reg_off_w;
    logic [31:0]   io_base_w;
    logic [31:0]   win_off_w;

    assign a          = req.addr;
    assign io_w       = is_io(a, mode_s2_r);
    // Only bits 28:0 count once I/O space is selected
    assign region_w   = a[REGION_MSB:REGION_LSB];
    assign ns_node_w  = a[NODE_MSB:NODE_LSB];
    assign win_node_w = a[WIN_NODE_MSB:WIN_NODE_LSB];
    assign priv_w     = io_w && (region_w <= PRIV_LAST);
    assign nodesp_w   = io_w && (region_w == NODESPACE_RG);
    assign window_w   = io_w && !priv_w && !nodesp_w;
    assign ns_impl_w  = (ns_node_w != NODE_NONE_LO) && (ns_node_w != NODE_NONE_HI);
    assign win_impl_w = has_window(win_node_w);
    assign io_base_w  = mode_s2_r ? IO_BASE_30 : IO_BASE_32;
    assign node_base_w = mode_s2_r ? NODE_BASE_30 : NODE_BASE_32;
    // Node region base: nodespace base plus id times stride
    assign own_base_w = node_base_w + NODE_STRIDE * {28'h0, node_s2_r};
    assign reg_off_w  = a[REG_OFF_MSB:0];
    assign win_off_w  = {7'h00, a[WIN_OFF_MSB:0]};

    // Target classification; unclaimed holes report NONE
    always_comb begin
        dec_w.node = NODE_NONE_LO;
        dec_w.own  = 1'b0;
        dec_w.tgt  = IOSAD_TGT_NONE;
        if (!req.valid) begin
            dec_w.tgt = IOSAD_TGT_NONE;
        end else if (!io_w) begin
            dec_w.tgt = IOSAD_TGT_MEMORY;
        end else if (priv_w) begin
            dec_w.tgt = IOSAD_TGT_PRIV;
        end else if (nodesp_w && ns_impl_w) begin
            dec_w.tgt  = IOSAD_TGT_NODE;
            dec_w.node = ns_node_w;
            dec_w.own  = ({a[31:REG_OFF_MSB+1], {(REG_OFF_MSB+1){1'b0}}} == own_base_w);
        end else if (window_w && win_impl_w) begin
            dec_w.tgt  = IOSAD_TGT_WINDOW;
            dec_w.node = win_node_w;
            dec_w.own  = brg_s2_r && (win_node_w == node_s2_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file of this node
    logic [31:0] bus_error_r,   bus_error_nxt;
    logic [31:0] bus_err_ext_r, bus_err_ext_nxt;
    logic        reg_dev_w, reg_ber_w, reg_bee_w, reg_hit_w;
    logic        own_node_w, own_win_w, fwd_ok_w;
    logic [31:0] rd_data_w;

    assign own_node_w = (dec_w.tgt == IOSAD_TGT_NODE) && dec_w.own;
    assign own_win_w  = (dec_w.tgt == IOSAD_TGT_WINDOW) && dec_w.own;
    // Register select within own region
    assign reg_dev_w  = own_node_w && (reg_off_w == OFF_DEVICE_TYPE);
    assign reg_ber_w  = own_node_w && (reg_off_w == OFF_BUS_ERROR);
    assign reg_bee_w  = own_node_w && (reg_off_w == OFF_BUS_ERR_EXT);
    assign reg_hit_w  = reg_dev_w || reg_ber_w || reg_bee_w;
    // Only longword references are re-issued
    assign fwd_ok_w   = own_win_w && (req.len == LEN_LONGWORD);

    // Read data select
    assign rd_data_w = reg_dev_w ? device_type_val :
                       reg_ber_w ? bus_error_r :
                       reg_bee_w ? bus_err_ext_r : ZERO32;

    // Error capture: write-one-to-clear, hardware set wins over clear
    always_comb begin
        bus_error_nxt   = bus_error_r;
        bus_err_ext_nxt = bus_err_ext_r;
        if (req.write && reg_ber_w)
            bus_error_nxt = bus_error_r & ~req.wdata;
        if (req.write && reg_bee_w)
            bus_err_ext_nxt = bus_err_ext_r & ~req.wdata;
        if (err_s2_r) begin
            bus_error_nxt   = bus_error_nxt | err_info;
            bus_err_ext_nxt = bus_err_ext_nxt | err_info;
        end
    end

    // Error register storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_error_r   <= ZERO32;
            bus_err_ext_r <= ZERO32;
        end else begin
            bus_error_r   <= bus_error_nxt;
            bus_err_ext_r <= bus_err_ext_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers
    iosad_fwd_t fwd_nxt;

    // Secondary bus request: I/O base plus window offset only
    always_comb begin
        fwd_nxt.valid    = fwd_ok_w;
        fwd_nxt.write    = req.write;
        fwd_nxt.sec_node = a[SEC_NODE_MSB:SEC_NODE_LSB];
        fwd_nxt.addr     = io_base_w + win_off_w;
        fwd_nxt.wdata    = req.wdata;
    end

    // Registered decode, claim and answers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dec_r        <= '0;
            local_hit_r  <= 1'b0;
            bus_claim_r  <= 1'b0;
            resp_valid_r <= 1'b0;
            resp_data_r  <= ZERO32;
            fwd_r        <= '0;
        end else begin
            dec_r        <= dec_w;
            local_hit_r  <= (dec_w.tgt == IOSAD_TGT_PRIV);
            bus_claim_r  <= own_node_w || fwd_ok_w;
            resp_valid_r <= own_node_w && !req.write;
            resp_data_r  <= (own_node_w && !req.write) ? rd_data_w : ZERO32;
            fwd_r        <= fwd_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> sim/iosad_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iosad_decoder_asserts (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  mode30,
    input wire logic [3:0]            node_id,
    input wire logic                  is_bridge,
    input wire logic [31:0]           device_type_val,
    input wire iosad_pkg::iosad_req_t req,
    input wire iosad_pkg::iosad_dec_t dec_r,
    input wire logic                  local_hit_r,
    input wire logic                  bus_claim_r,
    input wire logic                  resp_valid_r,
    input wire logic [31:0]           resp_data_r,
    input wire iosad_pkg::iosad_fwd_t fwd_r
);
    import iosad_pkg::*;
    // Classify the raw reference; straps are held steady by the bench
    wire logic [31:0] a_w   = req.addr;
    wire logic        io_w  = mode30 ? (a_w[31:30] == 2'h0 && a_w[29]) : (a_w[31:29] == IO_HI_ONES);
    wire logic [5:0]  rg_w  = a_w[28:23];
    wire logic [3:0]  nd_w  = a_w[22:19];
    wire logic [3:0]  wn_w  = a_w[28:25];
    wire logic        iv_w  = req.valid && io_w;
    wire logic        nsp_w = iv_w && rg_w == NODESPACE_RG;
    wire logic        ok_w  = node_id != NODE_NONE_LO && node_id != NODE_NONE_HI;
    wire logic        me_w  = nsp_w && nd_w == node_id && ok_w;
    wire logic        win_w = (wn_w >= WIN_LO_FIRST && wn_w <= WIN_LO_LAST) ||
                              (wn_w >= WIN_HI_FIRST && wn_w <= WIN_HI_LAST);
    wire logic        fw_w  = iv_w && win_w && wn_w == node_id && is_bridge && req.len == LEN_LONGWORD;
    wire logic [31:0] fa_w  = (mode30 ? IO_BASE_30 : IO_BASE_32) | {7'h00, a_w[24:0]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_priv_stays_local: assert property (iv_w && rg_w <= PRIV_LAST |=> local_hit_r && !bus_claim_r)
        else $error("private reference left the node");
    a_own_node_claim: assert property (me_w |=> bus_claim_r && dec_r.tgt == IOSAD_TGT_NODE && dec_r.own)
        else $error("own register region not claimed");
    a_dead_node_quiet: assert property (
        nsp_w && (nd_w == NODE_NONE_LO || nd_w == NODE_NONE_HI) |=> !bus_claim_r && !resp_valid_r)
        else $error("unimplemented node region answered");
    a_dead_window_quiet: assert property (
        iv_w && rg_w > NODESPACE_RG && !win_w |=> !bus_claim_r && !fwd_r.valid)
        else $error("unassigned window claimed");
    a_fwd_address: assert property (
        fw_w |=> fwd_r.valid && fwd_r.addr == $past(fa_w) && fwd_r.write == $past(req.write))
        else $error("window reference not re-issued correctly");
    a_short_no_fwd: assert property (req.valid && req.len != LEN_LONGWORD |=> !fwd_r.valid)
        else $error("non-longword reference forwarded");
    a_sec_node_field: assert property (fw_w |=> fwd_r.sec_node == $past(a_w[16:13]))
        else $error("secondary node number wrong");
    a_memory_ignored: assert property (
        req.valid && !io_w |=> !bus_claim_r && !local_hit_r && !fwd_r.valid)
        else $error("memory reference decoded as I/O");
    a_devtype_read: assert property (
        me_w && !req.write && a_w[18:0] == OFF_DEVICE_TYPE |=>
        resp_valid_r && resp_data_r == $past(device_type_val))
        else $error("device_type read wrong");
endmodule

bind iosad_decoder iosad_decoder_asserts iosad_decoder_asserts_inst (
    .clk(clk), .rstn(rstn), .mode30(mode30), .node_id(node_id), .is_bridge(is_bridge),
    .device_type_val(device_type_val), .req(req), .dec_r(dec_r), .local_hit_r(local_hit_r),
    .bus_claim_r(bus_claim_r), .resp_valid_r(resp_valid_r), .resp_data_r(resp_data_r), .fwd_r(fwd_r)
);
`default_nettype wire

// >>> sim/iosad_cmdr.sv
`timescale 1ns/1ps
`default_nettype none
module iosad_cmdr (
    input  wire logic                 clk,
    output var iosad_pkg::iosad_req_t req
);
    import iosad_pkg::*;
    // Bus idle at start
    initial req = '0;
    // One-cycle reference; idle lines show inverted values so stale data never matches
    task automatic issue(input logic w, input logic [1:0] ln, input logic [31:0] ad, input logic [31:0] wd);
        @(negedge clk);
        req = '{valid: 1'b1, write: w, len: ln, addr: ad, wdata: wd};
        @(negedge clk);
        req = '{valid: 1'b0, write: ~w, len: ~ln, addr: ~ad, wdata: ~wd};
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import iosad_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        mode30, is_bridge, err_event;
    logic [3:0]  node_id;
    logic [31:0] dval, einfo;
    iosad_req_t  req;
    iosad_dec_t  dec_r;
    iosad_fwd_t  fwd_r;
    logic        local_hit_r, bus_claim_r, resp_valid_r;
    logic [31:0] resp_data_r;
    int          err_total = 0;
    int          total_checks = 0;
    logic [31:0] holes [11] = '{32'hE000_0010, 32'hE180_0000, 32'hE1F8_0000, 32'hE198_0000, 32'hEC00_0000,
                               32'hEE00_0000, 32'hF000_0000, 32'hF200_0000, 32'hFE00_0000, 32'h0000_1000, 32'hE400_0000};
    logic [31:0] offs [2] = '{32'h4, 32'h34};
    wire logic [31:0] flags = {28'h0, local_hit_r, bus_claim_r, resp_valid_r, fwd_r.valid};

    // Clock
    always #2 clk = ~clk;

    iosad_cmdr iosad_cmdr_inst (.clk(clk), .req(req));
    iosad_decoder iosad_decoder_inst (
        .clk(clk), .rstn(rstn), .mode30(mode30), .node_id(node_id), .is_bridge(is_bridge),
        .device_type_val(dval), .err_event(err_event), .err_info(einfo), .req(req), .dec_r(dec_r),
        .local_hit_r(local_hit_r), .bus_claim_r(bus_claim_r), .resp_valid_r(resp_valid_r),
        .resp_data_r(resp_data_r), .fwd_r(fwd_r)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic rf(input logic w, input logic [1:0] ln, input logic [31:0] ad, input logic [31:0] wd);
        iosad_cmdr_inst.issue(w, ln, ad, wd);
    endtask

    // Hang guard
    initial begin
        #100us;
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        mode30 = 1'b0;
        node_id = 4'hE;
        is_bridge = 1'b1;
        dval = 32'h1234_5678;
        err_event = 1'b0;
        einfo = 32'h0000_0A05;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        rf(1'b0, LEN_LONGWORD, 32'hE1F0_0000, 32'h0);
        chk(flags, 32'h6);
        chk(resp_data_r, 32'h1234_5678);
        chk({29'h0, dec_r.tgt}, {29'h0, IOSAD_TGT_NODE});
        chk({28'h0, dec_r.node}, 32'hE);
        chk({31'h0, dec_r.own}, 32'h1);
        foreach (offs[i]) begin
            rf(1'b1, LEN_LONGWORD, 32'hE1F0_0000 + offs[i], 32'hFFFF_FFFF);
            err_event = 1'b1;
            repeat (2) @(negedge clk);
            err_event = 1'b0;
            repeat (4) @(negedge clk);
            rf(1'b0, LEN_LONGWORD, 32'hE1F0_0000 + offs[i], 32'h0);
            chk(resp_data_r, 32'h0000_0A05);
            rf(1'b1, LEN_LONGWORD, 32'hE1F0_0000 + offs[i], 32'hFFFF_FFFF);
            rf(1'b0, LEN_LONGWORD, 32'hE1F0_0000 + offs[i], 32'h0);
            chk(resp_data_r, 32'h0);
        end
        foreach (holes[i]) begin
            rf(1'b0, LEN_LONGWORD, holes[i], 32'h0);
            chk(flags, (i == 0) ? 32'h8 : 32'h0);
        end
        rf(1'b1, LEN_LONGWORD, 32'hFC00_8000, 32'hCAFE_0001);
        chk({31'h0, fwd_r.valid}, 32'h1);
        chk(flags, 32'h5);
        chk({31'h0, fwd_r.write}, 32'h1);
        chk({29'h0, dec_r.tgt}, {29'h0, IOSAD_TGT_WINDOW});
        chk({28'h0, dec_r.node}, 32'hE);
        chk(fwd_r.addr, 32'hE000_8000);
        chk({28'h0, fwd_r.sec_node}, 32'h4);
        chk(fwd_r.wdata, 32'hCAFE_0001);
        rf(1'b0, LEN_LONGWORD, 32'hFDFF_FFFC, 32'h0);
        chk(fwd_r.addr, 32'hE1FF_FFFC);
        chk({28'h0, fwd_r.sec_node}, 32'hF);
        rf(1'b1, 2'h1, 32'hFC00_8000, 32'h0);
        chk({31'h0, fwd_r.valid}, 32'h0);
        mode30 = 1'b1;
        repeat (4) @(negedge clk);
        rf(1'b0, LEN_LONGWORD, 32'h21F0_0000, 32'h0);
        chk(resp_data_r, 32'h1234_5678);
        rf(1'b0, LEN_LONGWORD, 32'h3C00_8000, 32'h0);
        chk(fwd_r.addr, 32'h2000_8000);
        rf(1'b0, LEN_LONGWORD, 32'hE1F0_0000, 32'h0);
        chk(flags, 32'h0);
        is_bridge = 1'b0;
        repeat (4) @(negedge clk);
        rf(1'b0, LEN_LONGWORD, 32'h3C00_8000, 32'h0);
        chk({31'h0, fwd_r.valid}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
